// ===== hw/mag_params.svh
// Constants for the address generation block: widths, fixed RAM areas,
// table flag bit positions and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef MAG_PARAMS_SVH
`define MAG_PARAMS_SVH
`define MAG_RAM_AW        10
`define MAG_ROM_AW        12
`define MAG_ROM_DW        10
`define MAG_PAGE_BITS     8
`define MAG_MEMREG_BASE   10'h040
`define MAG_ZP_BITS       6
`define MAG_TBL_ACC_BIT   8
`define MAG_TBL_PORT_BIT  9
`define MAG_PC_RESET      12'h000
`define MAG_NIB_RESET     4'h0
`endif

// ===== hw/mag_pkg.sv
// Types for the address generation block: command codes and sequencer states.
// Assumes nothing beyond the constants header.
`include "mag_params.svh"
package mag_pkg;
  typedef enum logic [3:0] {
    MAG_OP_NOP         = 4'h0,
    MAG_OP_RAM_IND     = 4'h1,
    MAG_OP_RAM_DIR     = 4'h2,
    MAG_OP_MEMREG_LOAD = 4'h3,
    MAG_OP_MEMREG_SWAP = 4'h4,
    MAG_OP_LONG_JUMP   = 4'h5,
    MAG_OP_FAR_JUMP    = 4'h6,
    MAG_OP_CALL        = 4'h7,
    MAG_OP_ZERO_CALL   = 4'h8,
    MAG_OP_IN_PAGE     = 4'h9,
    MAG_OP_TABLE_JUMP  = 4'hA,
    MAG_OP_TABLE_FETCH = 4'hB
  } mag_op_t;

  typedef enum logic [1:0] {
    MAG_ST_IDLE = 2'b00,
    MAG_ST_READ = 2'b01,
    MAG_ST_LOAD = 2'b10
  } mag_state_t;
endpackage

// ===== hw/mag_rom.sv
// Program memory for the address generation block, one read port, one load port.
// Assumes the load port is used only while the core is idle.
`timescale 1ns/1ps
`default_nettype none
`include "mag_params.svh"
module mag_rom
  import mag_pkg::*;
#(
  parameter int AW = `MAG_ROM_AW,
  parameter int DW = `MAG_ROM_DW
) (
  input  wire logic          mclk,
  input  wire logic          ce,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata,
  input  wire logic          load_we,
  input  wire logic [AW-1:0] load_addr,
  input  wire logic [DW-1:0] load_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array or read register, so it maps to block RAM
  always_ff @(posedge mclk) begin
    if (ce && load_we) begin
      mem[load_addr] <= load_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (ce) begin
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire

// ===== hw/mag_agen.sv
// Address generation for a 4-bit core: RAM addresses, branch targets, table fetch.
// Assumes the decoder presents one command per cmd_valid while cmd_ready is high.
//
// Overview of operation
// RULE_01: Register-indirect RAM mode joins pointers a, b and c into one 10-bit address.
// RULE_02: Direct RAM mode takes its 10-bit address from the second instruction word.
// RULE_03: Sixteen memory register digits sit at a fixed RAM area for the two memreg ops.
// RULE_04: Long jump, far jump and call reach any address of the whole ROM.
// RULE_05: In-page jump stays inside the current 256-word page, except when it sits at the page's last word.
// RULE_06: Short calls reach only the zero-page area ending at word 003F.
// RULE_07: Table jump targets the address built from a 4-bit immediate, accumulator and aux.
// RULE_08: Table fetch reads the ROM word at the table jump target.
// RULE_09: Fetched bit 8 set loads the low byte into accumulator and aux.
// RULE_10: Fetched bit 9 set loads the low byte into both port output registers.
// RULE_11: With both bits set, both loads happen in the same cycle.
// RULE_12: Table fetch leaves the counter on the next instruction.
// RULE_13: An in-page jump at the last word of a page lands in the following page.
// RULE_14: With neither bit set, table fetch changes no data or port register.
`timescale 1ns/1ps
`default_nettype none
`include "mag_params.svh"
module mag_agen
  import mag_pkg::*;
#(
  parameter int ROM_AW = `MAG_ROM_AW
) (
  input  wire logic                   mclk,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic                   cmd_valid,
  input  wire mag_op_t                cmd_op,
  input  wire logic [9:0]             cmd_imm,
  input  wire logic [9:0]             cmd_ext,
  input  wire logic [1:0]             ptr_a,
  input  wire logic [3:0]             ptr_b,
  input  wire logic [3:0]             ptr_c,
  input  wire logic                   reg_wr,
  input  wire logic [3:0]             reg_acc_din,
  input  wire logic [3:0]             reg_aux_din,
  input  wire logic                   load_we,
  input  wire logic [ROM_AW-1:0]      load_addr,
  input  wire logic [9:0]             load_data,
  output logic                        cmd_ready,
  output logic [ROM_AW-1:0]           pc,
  output logic [`MAG_RAM_AW-1:0]      ram_addr,
  output logic                        ram_valid,
  output logic                        ram_swap,
  output logic                        call_taken,
  output logic [ROM_AW-1:0]           ret_addr,
  output logic [3:0]                  acc,
  output logic [3:0]                  aux,
  output logic [3:0]                  port_one_out,
  output logic [3:0]                  port_two_out
);
  // Page split and table target need at least 10 address bits
  if (ROM_AW < 10 || ROM_AW > 20) begin : g_rom_aw_check
    $error("ROM_AW out of range");
  end

  mag_state_t        state;
  logic [ROM_AW-1:0] tbl_addr;
  logic [9:0]        rom_rdata;
  logic              take;
  logic [ROM_AW-1:0] pc_inc;

  assign take   = ce && cmd_valid && cmd_ready;
  assign pc_inc = pc + ROM_AW'(1);

  // Long forms: spare immediate bits extend the second word past 10 bits
  function automatic logic [ROM_AW-1:0] long_target(input logic [9:0] imm,
                                                    input logic [9:0] ext);
    logic [19:0] wide;
    wide = {imm, ext};
    return wide[ROM_AW-1:0];
  endfunction

  // Shared by table jump and table fetch
  function automatic logic [ROM_AW-1:0] table_target(input logic [3:0] imm,
                                                     input logic [3:0] hi,
                                                     input logic [3:0] lo);
    return ROM_AW'({imm, hi, lo});
  endfunction

  mag_rom #(.AW(ROM_AW), .DW(10)) u_rom (
    .mclk      (mclk),
    .ce        (ce),
    .raddr     (tbl_addr),
    .rdata     (rom_rdata),
    .load_we   (load_we),
    .load_addr (load_addr),
    .load_data (load_data)
  );

  // Sequencer; table fetch needs a read cycle and a load cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state     <= MAG_ST_IDLE;
      cmd_ready <= 1'b1;
      tbl_addr  <= '0;
    end else if (ce) begin
      case (state)
        MAG_ST_IDLE: begin
          if (take && cmd_op == MAG_OP_TABLE_FETCH) begin
            tbl_addr  <= table_target(cmd_imm[3:0], aux, acc); // see RULE_08
            state     <= MAG_ST_READ;
            cmd_ready <= 1'b0;
          end
        end
        MAG_ST_READ: state <= MAG_ST_LOAD;
        MAG_ST_LOAD: begin
          state     <= MAG_ST_IDLE;
          cmd_ready <= 1'b1;
        end
        default: begin
          state     <= MAG_ST_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end

  // Program counter
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pc <= ROM_AW'(`MAG_PC_RESET);
    end else if (take) begin
      case (cmd_op)
        MAG_OP_RAM_DIR:    pc <= pc + ROM_AW'(2); // see RULE_02
        MAG_OP_LONG_JUMP,
        MAG_OP_FAR_JUMP,
        MAG_OP_CALL:       pc <= long_target(cmd_imm, cmd_ext); // see RULE_04
        MAG_OP_ZERO_CALL:  pc <= ROM_AW'(cmd_imm[`MAG_ZP_BITS-1:0]); // see RULE_06
        // Page comes from the incremented counter, so the last word rolls over
        MAG_OP_IN_PAGE:    pc <= {pc_inc[ROM_AW-1:`MAG_PAGE_BITS],
                                  cmd_imm[`MAG_PAGE_BITS-1:0]}; // see RULE_05 see RULE_13
        MAG_OP_TABLE_JUMP: pc <= table_target(cmd_imm[3:0], aux, acc); // see RULE_07
        MAG_OP_TABLE_FETCH: pc <= pc_inc; // see RULE_12
        default:           pc <= pc_inc;
      endcase
    end
  end

  // Call return address, two words for the long call
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      call_taken <= 1'b0;
      ret_addr   <= '0;
    end else if (ce) begin
      call_taken <= take && (cmd_op == MAG_OP_CALL || cmd_op == MAG_OP_ZERO_CALL);
      if (take && cmd_op == MAG_OP_CALL) begin
        ret_addr <= pc + ROM_AW'(2);
      end else if (take && cmd_op == MAG_OP_ZERO_CALL) begin
        ret_addr <= pc_inc;
      end
    end
  end

  // RAM address forming
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      ram_addr  <= '0;
      ram_valid <= 1'b0;
      ram_swap  <= 1'b0;
    end else if (ce) begin
      ram_valid <= 1'b0;
      ram_swap  <= 1'b0;
      if (take) begin
        case (cmd_op)
          MAG_OP_RAM_IND: begin
            ram_addr  <= {ptr_a, ptr_b, ptr_c}; // see RULE_01
            ram_valid <= 1'b1;
          end
          MAG_OP_RAM_DIR: begin
            ram_addr  <= cmd_ext; // see RULE_02
            ram_valid <= 1'b1;
          end
          MAG_OP_MEMREG_LOAD, MAG_OP_MEMREG_SWAP: begin
            ram_addr  <= `MAG_MEMREG_BASE | {6'h00, cmd_imm[3:0]}; // see RULE_03
            ram_valid <= 1'b1;
            ram_swap  <= (cmd_op == MAG_OP_MEMREG_SWAP);
          end
          default: ram_valid <= 1'b0;
        endcase
      end
    end
  end

  // Accumulator and aux; a table load outranks a core write in the same cycle
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      acc <= `MAG_NIB_RESET;
      aux <= `MAG_NIB_RESET;
    end else if (ce) begin
      if (state == MAG_ST_LOAD && rom_rdata[`MAG_TBL_ACC_BIT]) begin
        acc <= rom_rdata[3:0]; // see RULE_09 see RULE_11
        aux <= rom_rdata[7:4];
      end else if (reg_wr) begin
        acc <= reg_acc_din;
        aux <= reg_aux_din;
      end
    end
  end

  // Port output registers, touched only by table fetch
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      port_one_out <= `MAG_NIB_RESET;
      port_two_out <= `MAG_NIB_RESET;
    end else if (ce && state == MAG_ST_LOAD && rom_rdata[`MAG_TBL_PORT_BIT]) begin
      port_one_out <= rom_rdata[3:0]; // see RULE_10 see RULE_11 see RULE_14
      port_two_out <= rom_rdata[7:4];
    end
  end

  AST_RAM_IND: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_01
    take && cmd_op == MAG_OP_RAM_IND |=>
      ram_valid && ram_addr == {$past(ptr_a), $past(ptr_b), $past(ptr_c)})
    else $error("indirect RAM address wrong");

  AST_RAM_DIR: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_02
    take && cmd_op == MAG_OP_RAM_DIR |=>
      ram_addr == $past(cmd_ext) && pc == $past(pc) + ROM_AW'(2))
    else $error("direct RAM access wrong");

  AST_MEMREG: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_03
    take && (cmd_op == MAG_OP_MEMREG_LOAD || cmd_op == MAG_OP_MEMREG_SWAP) |=>
      ram_valid && ram_addr[9:4] == 6'h04 && ram_addr[3:0] == $past(cmd_imm[3:0]))
    else $error("memory register address wrong");

  AST_LONG: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_04
    take && (cmd_op == MAG_OP_LONG_JUMP || cmd_op == MAG_OP_FAR_JUMP ||
             cmd_op == MAG_OP_CALL) |=>
      pc == long_target($past(cmd_imm), $past(cmd_ext)))
    else $error("long branch target wrong");

  AST_IN_PAGE: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_05
    take && cmd_op == MAG_OP_IN_PAGE && pc[7:0] != 8'hFF |=>
      pc[ROM_AW-1:8] == $past(pc[ROM_AW-1:8]) && pc[7:0] == $past(cmd_imm[7:0]))
    else $error("in-page jump left its page");

  AST_PAGE_EDGE: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_13
    take && cmd_op == MAG_OP_IN_PAGE && pc[7:0] == 8'hFF |=>
      pc[ROM_AW-1:8] == $past(pc[ROM_AW-1:8]) + (ROM_AW-8)'(1))
    else $error("page edge jump stayed in old page");

  AST_ZERO_CALL: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_06
    take && cmd_op == MAG_OP_ZERO_CALL |=> pc <= ROM_AW'(12'h03F) && call_taken)
    else $error("short call outside zero page");

  AST_TBL_JUMP: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_07
    take && cmd_op == MAG_OP_TABLE_JUMP |=>
      pc == ROM_AW'({$past(cmd_imm[3:0]), $past(aux), $past(acc)}))
    else $error("table jump target wrong");

  AST_TBL_FETCH: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_12
    take && cmd_op == MAG_OP_TABLE_FETCH |=>
      pc == $past(pc) + ROM_AW'(1) && !cmd_ready && state == MAG_ST_READ)
    else $error("table fetch disturbed counter");

  AST_ACC_LOAD: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_09
    ce && state == MAG_ST_LOAD && rom_rdata[8] |=>
      acc == $past(rom_rdata[3:0]) && aux == $past(rom_rdata[7:4]))
    else $error("accumulator not loaded from table");

  AST_PORT_LOAD: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_10
    ce && state == MAG_ST_LOAD && rom_rdata[9] |=>
      port_one_out == $past(rom_rdata[3:0]) && port_two_out == $past(rom_rdata[7:4]))
    else $error("ports not loaded from table");

  AST_NO_LOAD: assert property (@(posedge mclk) disable iff (!nrst) // see RULE_14
    ce && state == MAG_ST_LOAD && rom_rdata[9:8] == 2'b00 && !reg_wr |=>
      $stable(acc) && $stable(aux) && $stable(port_one_out) && $stable(port_two_out))
    else $error("table fetch changed data without flag");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the address generation block: table of commands, then table fetch.
// Assumes mag_agen with its default ROM width and the ROM load port for program memory.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mag_pkg::*;
  typedef struct {
    mag_op_t     op;
    logic [9:0]  imm;
    logic [9:0]  ext;
    logic [11:0] pc;
    logic [9:0]  ram;
    logic        rv;
    logic        sw;
    logic        ct;
    logic [11:0] ret;
  } mag_row_t;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        ce = 1'b1;
  logic        cmd_valid = 1'b0;
  mag_op_t     cmd_op = MAG_OP_NOP;
  logic [9:0]  cmd_imm = 10'h000;
  logic [9:0]  cmd_ext = 10'h000;
  logic        reg_wr = 1'b0;
  logic [3:0]  reg_acc_din = 4'h0;
  logic [3:0]  reg_aux_din = 4'h0;
  logic [1:0]  ptr_a = 2'h2;
  logic [3:0]  ptr_b = 4'h5;
  logic [3:0]  ptr_c = 4'hA;
  logic        load_we = 1'b0;
  logic [11:0] load_addr = 12'h000;
  logic [9:0]  load_data = 10'h000;
  logic        cmd_ready, ram_valid, ram_swap, call_taken;
  logic [11:0] pc, ret_addr;
  logic [9:0]  ram_addr;
  logic [3:0]  acc, aux, port_one_out, port_two_out;
  logic [11:0] exp_pc;
  int          n_mismatch = 0;
  int          checked = 0;
  mag_row_t    rows [12];

  always #10 mclk = ~mclk;

  mag_agen i_dut (
    .mclk(mclk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_imm(cmd_imm), .cmd_ext(cmd_ext), .ptr_a(ptr_a), .ptr_b(ptr_b), .ptr_c(ptr_c),
    .reg_wr(reg_wr), .reg_acc_din(reg_acc_din), .reg_aux_din(reg_aux_din),
    .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .cmd_ready(cmd_ready), .pc(pc), .ram_addr(ram_addr), .ram_valid(ram_valid),
    .ram_swap(ram_swap), .call_taken(call_taken), .ret_addr(ret_addr), .acc(acc),
    .aux(aux), .port_one_out(port_one_out), .port_two_out(port_two_out)
  );

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Reloads acc 3 and aux C first, so every fetch aims at {imm, C, 3}
  task automatic tfetch(input logic [9:0] imm, input logic [3:0] ea, eb, e1, e2);
    int k;
    reg_wr = 1'b1;
    reg_acc_din = 4'h3;
    reg_aux_din = 4'hC;
    @(negedge mclk);
    reg_wr = 1'b0;
    cmd_valid = 1'b1;
    cmd_op = MAG_OP_TABLE_FETCH;
    cmd_imm = imm;
    @(negedge mclk);
    exp_pc = exp_pc + 12'h001;
    cmd_op = MAG_OP_RAM_IND;
    chk(cmd_ready, 0, "ready during fetch");
    @(negedge mclk);
    chk(ram_valid, 0, "command refused while busy");
    chk(cmd_ready, 0, "ready second cycle");
    cmd_valid = 1'b0;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 4) begin
      @(negedge mclk);
      k++;
    end
    if (k == 4) begin
      n_mismatch++;
      give_verdict();
    end else begin
      chk(k[15:0], 1, "fetch latency");
      chk(acc, ea, "acc");
      chk(aux, eb, "aux");
      chk(port_one_out, e1, "port one");
      chk(port_two_out, e2, "port two");
      chk(pc, exp_pc, "pc after fetch");
    end
  endtask

  initial begin
    rows = '{
      '{MAG_OP_RAM_IND,     10'h000, 10'h000, 12'h001, 10'h25A, 1, 0, 0, 12'h000},
      '{MAG_OP_RAM_DIR,     10'h000, 10'h3C5, 12'h003, 10'h3C5, 1, 0, 0, 12'h000},
      '{MAG_OP_MEMREG_LOAD, 10'h0F7, 10'h000, 12'h004, 10'h047, 1, 0, 0, 12'h000},
      '{MAG_OP_MEMREG_SWAP, 10'h00F, 10'h000, 12'h005, 10'h04F, 1, 1, 0, 12'h000},
      '{MAG_OP_LONG_JUMP,   10'h003, 10'h2FE, 12'hEFE, 10'h04F, 0, 0, 0, 12'h000},
      '{MAG_OP_IN_PAGE,     10'h012, 10'h000, 12'hE12, 10'h04F, 0, 0, 0, 12'h000},
      '{MAG_OP_LONG_JUMP,   10'h000, 10'h1FF, 12'h1FF, 10'h04F, 0, 0, 0, 12'h000},
      '{MAG_OP_IN_PAGE,     10'h034, 10'h000, 12'h234, 10'h04F, 0, 0, 0, 12'h000},
      '{MAG_OP_CALL,        10'h001, 10'h0AB, 12'h4AB, 10'h04F, 0, 0, 1, 12'h236},
      '{MAG_OP_ZERO_CALL,   10'h3FF, 10'h000, 12'h03F, 10'h04F, 0, 0, 1, 12'h4AC},
      '{MAG_OP_FAR_JUMP,    10'h002, 10'h001, 12'h801, 10'h04F, 0, 0, 0, 12'h4AC},
      '{MAG_OP_TABLE_JUMP,  10'h005, 10'h000, 12'h5C3, 10'h04F, 0, 0, 0, 12'h4AC}
    };
    repeat (6) @(negedge mclk);
    chk(pc, 0, "reset pc");
    chk(cmd_ready, 1, "reset ready");
    chk({acc, aux, port_one_out, port_two_out}, 0, "reset data");
    nrst = 1'b1;
    // Program words: bit 8 only, bit 9 only, both, neither
    load_we = 1'b1;
    for (int i = 0; i < 4; i++) begin
      load_addr = {i[3:0] + 4'h1, 8'hC3};
      load_data = (i == 0) ? 10'h1A5 : (i == 1) ? 10'h2B6 : (i == 2) ? 10'h3C7 : 10'h0E9;
      @(negedge mclk);
    end
    load_we = 1'b0;
    reg_wr = 1'b1;
    reg_acc_din = 4'h3;
    reg_aux_din = 4'hC;
    @(negedge mclk);
    reg_wr = 1'b0;
    // Back to back, one take per edge
    for (int i = 0; i < 12; i++) begin
      cmd_valid = 1'b1;
      cmd_op = rows[i].op;
      cmd_imm = rows[i].imm;
      cmd_ext = rows[i].ext;
      @(negedge mclk);
      chk(pc, rows[i].pc, "pc");
      chk(ram_addr, rows[i].ram, "ram addr");
      chk(ram_valid, rows[i].rv, "ram valid");
      chk(ram_swap, rows[i].sw, "ram swap");
      chk(call_taken, rows[i].ct, "call");
      chk(ret_addr, rows[i].ret, "return addr");
    end
    cmd_valid = 1'b0;
    exp_pc = 12'h5C3;
    tfetch(10'h001, 4'h5, 4'hA, 4'h0, 4'h0);
    tfetch(10'h002, 4'h3, 4'hC, 4'h6, 4'hB);
    tfetch(10'h003, 4'h7, 4'hC, 4'h7, 4'hC);
    tfetch(10'h004, 4'h3, 4'hC, 4'h7, 4'hC);
    // Clock enable low must freeze a live pulse and hold off a pending command
    cmd_valid = 1'b1;
    cmd_op = MAG_OP_RAM_DIR;
    cmd_ext = 10'h1B4;
    @(negedge mclk);
    ce = 1'b0;
    cmd_op = MAG_OP_RAM_IND;
    repeat (2) @(negedge mclk);
    chk(pc, exp_pc + 12'h002, "frozen pc");
    chk(ram_addr, 10'h1B4, "frozen ram addr");
    chk(ram_valid, 1, "frozen ram valid");
    ce = 1'b1;
    cmd_valid = 1'b0;
    @(negedge mclk);
    chk(ram_valid, 0, "pulse ends after enable");
    chk(pc, exp_pc + 12'h002, "no take while frozen");
    nrst = 1'b0;
    @(negedge mclk);
    chk(pc, 0, "second reset pc");
    chk({acc, aux, port_one_out, port_two_out}, 0, "second reset data");
    chk({ram_valid, ram_swap, call_taken, cmd_ready}, 16'h0001, "second reset flags");
    chk(ram_addr, 0, "second reset ram addr");
    chk(ret_addr, 0, "second reset return addr");
    nrst = 1'b1;
    @(negedge mclk);
    give_verdict();
  end
endmodule
`default_nettype wire
